/* hw/svpc_pkg.sv */
// svpc_pkg: constants for the port vlan and transceiver config slice
// assumes one system clock; registers are written by the config loader
// Function
// - with the fallback enable set, a full duplex port whose full duplex partner lacks pause support drops to half duplex.
// - the pulse reduction control is active low and, when enabled, sends fewer link pulses while no cable is seen.
// - the upper byte of the first vlan register is port 1's membership mask, reset to all ones, own bit ignored.
// - the lower byte of the first vlan register is port 0's membership mask, reset to all ones, own bit ignored.
// - mask bits 0 to 7 stand for ports 0 to 7; set means same vlan, clear means outside.
package svpc_pkg;
	localparam int NUM_PORTS = 8;
	localparam int PORT_W = 3;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	// register offsets
	localparam logic [7:0] REG_XCVR_VERIFY = 8'h05;
	localparam logic [7:0] REG_TEST_MODE = 8'h06;
	localparam logic [7:0] REG_VLAN01 = 8'h07;
	// reset values
	localparam logic [15:0] XCVR_RESET = 16'h1008;
	localparam logic [15:0] TEST_RESET = 16'h0000;
	localparam logic [15:0] VLAN01_RESET = 16'hffff;
	// writable bits; reserved bits hold zero and read zero
	localparam logic [15:0] XCVR_WR_MASK = 16'h3fff;
	localparam logic [15:0] TEST_WR_MASK = 16'h007f;
	localparam logic [15:0] VLAN01_WR_MASK = 16'hffff;
	// field positions
	localparam int FALLBACK_EN_BIT = 12;
	localparam int PULSE_REDUCE_N_BIT = 3;
	localparam int VLAN_P1_LSB = 8;
	localparam int VLAN_P0_LSB = 0;
	localparam logic [2:0] PORT0 = 3'h0;
	localparam logic [2:0] PORT1 = 3'h1;
endpackage : svpc_pkg

/* hw/svpc_fwd_if.sv */
// svpc_fwd_if: forwarding request and vlan filter result
// assumes both ends share the system clock
`timescale 1ns/1ps
`default_nettype none
interface svpc_fwd_if;
	logic reqValid;
	logic [2:0] srcPort;
	logic [7:0] dstMask;
	logic [7:0] vlanMaskP0;
	logic [7:0] vlanMaskP1;
	logic allowValid;
	logic [7:0] allowMask;
	modport filt (input reqValid, srcPort, dstMask, vlanMaskP0, vlanMaskP1,
		output allowValid, allowMask);
	modport ctl (output reqValid, srcPort, dstMask, vlanMaskP0, vlanMaskP1,
		input allowValid, allowMask);
endinterface : svpc_fwd_if
`default_nettype wire

/* hw/svpc_fwd_filter.sv */
// svpc_fwd_filter: trims a frame's destination ports by vlan membership
// assumes requests and masks are on the system clock
`timescale 1ns/1ps
`default_nettype none
module svpc_fwd_filter (
	input wire logic clk,
	input wire logic rst,
	svpc_fwd_if.filt fwd
);
	logic [7:0] member;
	logic [7:0] allowMask_r;
	logic [7:0] allowMask_nxt;
	logic allowValid_r;
	logic allowValid_nxt;

	////////////////////////////////////////////////////////////////////////
	// pick the membership mask of the receiving port
	always_comb begin
		case (fwd.srcPort)
			svpc_pkg::PORT0: member = fwd.vlanMaskP0;
			svpc_pkg::PORT1: member = fwd.vlanMaskP1;
			// masks of ports 2-7 live in another slice, so pass here
			default: member = 8'hff;
		endcase
	end

	// bit i of the mask gates port i; the source bit is never used
	generate
		for (genvar i = 0; i < svpc_pkg::NUM_PORTS; i++) begin : g_port
			assign allowMask_nxt[i] = fwd.reqValid & fwd.dstMask[i] &
				member[i] & (fwd.srcPort != 3'(i));
		end
	endgenerate

	assign allowValid_nxt = fwd.reqValid;

	// result registered one cycle after the request
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			allowMask_r <= 8'h00;
			allowValid_r <= 1'b0;
		end else begin
			allowMask_r <= allowMask_nxt;
			allowValid_r <= allowValid_nxt;
		end
	end

	assign fwd.allowMask = allowMask_r;
	assign fwd.allowValid = allowValid_r;
endmodule : svpc_fwd_filter
`default_nettype wire

/* hw/svpc_config_top.sv */
// svpc_config_top: verification, test mode and first vlan registers,
// the duplex fallback and pulse reduction controls, and the vlan filter
// assumes port status inputs come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module svpc_config_top #(
	parameter int NumPorts = 8
) (
	input wire logic clk,
	input wire logic rst,
	// register port of the config loader
	input wire logic cfgWrEn,
	input wire logic cfgRdEn,
	input wire logic [7:0] cfgAddr,
	input wire logic [15:0] cfgWrData,
	output logic [15:0] cfgRdData,
	output logic cfgRdValid,
	// per-port negotiation status
	input wire logic [7:0] negFullDuplex,
	input wire logic [7:0] partnerFullDuplex,
	input wire logic [7:0] partnerPause,
	input wire logic [7:0] cableDetected,
	output logic [7:0] effFullDuplex,
	output logic [7:0] flpReduce,
	// raw test fields towards the transceivers
	output logic [15:0] xcvrTestBits,
	output logic [6:0] testModeBits,
	// forwarding request
	input wire logic fwdReqValid,
	input wire logic [2:0] fwdSrcPort,
	input wire logic [7:0] fwdDstMask,
	output logic fwdAllowValid,
	output logic [7:0] fwdAllowMask
);
	logic [15:0] xcvrReg_r;
	logic [15:0] xcvrReg_nxt;
	logic [15:0] testReg_r;
	logic [15:0] testReg_nxt;
	logic [15:0] vlanReg_r;
	logic [15:0] vlanReg_nxt;
	logic [15:0] rdData_r;
	logic [15:0] rdData_nxt;
	logic rdValid_r;
	logic rdValid_nxt;
	logic [7:0] effFull_r;
	logic [7:0] effFull_nxt;
	logic [7:0] flpReduce_r;
	logic [7:0] flpReduce_nxt;
	logic fallbackEn;
	logic pulseReduceN;
	logic selXcvr;
	logic selTest;
	logic selVlan;

	svpc_fwd_if fwd ();

	////////////////////////////////////////////////////////////////////////
	// the port width is fixed by the eight-bit masks
	generate
		if (NumPorts != svpc_pkg::NUM_PORTS) begin : g_bad_ports
			$error("svpc_config_top: NumPorts must be 8");
		end
		// field positions and masks must fit the sixteen-bit word
		if (svpc_pkg::DATA_W != 16) begin : g_bad_data
			$error("svpc_config_top: DATA_W must be 16");
		end
		if (svpc_pkg::ADDR_W != 8) begin : g_bad_addr
			$error("svpc_config_top: ADDR_W must be 8");
		end
		if (svpc_pkg::FALLBACK_EN_BIT >= svpc_pkg::DATA_W) begin : g_bad_fb
			$error("svpc_config_top: fallback bit outside the word");
		end
		if (svpc_pkg::PULSE_REDUCE_N_BIT >= svpc_pkg::DATA_W) begin : g_bad_pr
			$error("svpc_config_top: pulse bit outside the word");
		end
		if (svpc_pkg::VLAN_P1_LSB + 8 > svpc_pkg::DATA_W) begin : g_bad_p1
			$error("svpc_config_top: port 1 mask outside the word");
		end
		if (svpc_pkg::VLAN_P0_LSB + 8 > svpc_pkg::VLAN_P1_LSB) begin : g_bad_p0
			$error("svpc_config_top: port 0 mask overlaps port 1");
		end
		// reserved bits read zero, so no reset value may set them
		if ((svpc_pkg::XCVR_RESET & ~svpc_pkg::XCVR_WR_MASK) !=
			16'h0000) begin : g_bad_xr
			$error("svpc_config_top: reset sets a reserved bit");
		end
		if ((svpc_pkg::TEST_RESET & ~svpc_pkg::TEST_WR_MASK) !=
			16'h0000) begin : g_bad_tr
			$error("svpc_config_top: reset sets a reserved bit");
		end
		if ((svpc_pkg::VLAN01_RESET & ~svpc_pkg::VLAN01_WR_MASK) !=
			16'h0000) begin : g_bad_vr
			$error("svpc_config_top: reset sets a reserved bit");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// offset decode shared by writes and reads; unmapped offsets hit nothing
	always_comb begin
		selXcvr = 1'b0;
		selTest = 1'b0;
		selVlan = 1'b0;
		case (cfgAddr)
			svpc_pkg::REG_XCVR_VERIFY: selXcvr = 1'b1;
			svpc_pkg::REG_TEST_MODE: selTest = 1'b1;
			svpc_pkg::REG_VLAN01: selVlan = 1'b1;
			default: begin
				// nothing selected, so writes are ignored and reads give zero
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// register writes; reserved bits are masked so they stay zero
	always_comb begin
		xcvrReg_nxt = xcvrReg_r;
		testReg_nxt = testReg_r;
		vlanReg_nxt = vlanReg_r;
		if (cfgWrEn && selXcvr) begin
			xcvrReg_nxt = cfgWrData & svpc_pkg::XCVR_WR_MASK;
		end
		// test bits 6:0 are stored as written, reserved bits masked; zero is up to software
		if (cfgWrEn && selTest) begin
			testReg_nxt = cfgWrData & svpc_pkg::TEST_WR_MASK;
		end
		if (cfgWrEn && selVlan) begin
			vlanReg_nxt = cfgWrData & svpc_pkg::VLAN01_WR_MASK;
		end
	end

	// register store with documented reset values
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			xcvrReg_r <= svpc_pkg::XCVR_RESET;
			testReg_r <= svpc_pkg::TEST_RESET;
			vlanReg_r <= svpc_pkg::VLAN01_RESET;
		end else begin
			xcvrReg_r <= xcvrReg_nxt;
			testReg_r <= testReg_nxt;
			vlanReg_r <= vlanReg_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path; unmapped offsets read zero, answer one cycle later
	// a read and a write in one cycle return the old value
	always_comb begin
		rdValid_nxt = cfgRdEn;
		rdData_nxt = 16'h0000;
		if (cfgRdEn && selXcvr) begin
			rdData_nxt = xcvrReg_r;
		end
		if (cfgRdEn && selTest) begin
			rdData_nxt = testReg_r;
		end
		if (cfgRdEn && selVlan) begin
			rdData_nxt = vlanReg_r;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdData_r <= 16'h0000;
			rdValid_r <= 1'b0;
		end else begin
			rdData_r <= rdData_nxt;
			rdValid_r <= rdValid_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transceiver controls taken from the verification register
	assign fallbackEn = xcvrReg_r[svpc_pkg::FALLBACK_EN_BIT];
	assign pulseReduceN = xcvrReg_r[svpc_pkg::PULSE_REDUCE_N_BIT];

	// per-port duplex fallback and link pulse reduction
	generate
		for (genvar i = 0; i < svpc_pkg::NUM_PORTS; i++) begin : g_xcvr
			// only a full duplex partner without pause forces half duplex
			assign effFull_nxt[i] = negFullDuplex[i] & ~(fallbackEn &
				partnerFullDuplex[i] & ~partnerPause[i]);
			// active low enable; acts only while no cable is seen
			assign flpReduce_nxt[i] = ~pulseReduceN &
				~cableDetected[i];
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			effFull_r <= 8'h00;
			flpReduce_r <= 8'h00;
		end else begin
			effFull_r <= effFull_nxt;
			flpReduce_r <= flpReduce_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// vlan filter for frames; masks are split by owning port
	// sources 2-7 pass unfiltered, their masks live in another slice
	assign fwd.reqValid = fwdReqValid;
	assign fwd.srcPort = fwdSrcPort;
	assign fwd.dstMask = fwdDstMask;
	assign fwd.vlanMaskP0 = vlanReg_r[svpc_pkg::VLAN_P0_LSB +: 8];
	assign fwd.vlanMaskP1 = vlanReg_r[svpc_pkg::VLAN_P1_LSB +: 8];

	svpc_fwd_filter u_filter (
		.clk(clk),
		.rst(rst),
		.fwd(fwd)
	);

	////////////////////////////////////////////////////////////////////////
	// outputs; all come from flip-flops
	assign cfgRdData = rdData_r;
	assign cfgRdValid = rdValid_r;
	assign effFullDuplex = effFull_r;
	assign flpReduce = flpReduce_r;
	assign xcvrTestBits = xcvrReg_r;
	assign testModeBits = testReg_r[6:0];
	assign fwdAllowValid = fwd.allowValid;
	assign fwdAllowMask = fwd.allowMask;
endmodule : svpc_config_top
`default_nettype wire

/* dv/svpc_monitor.sv */
// svpc_monitor: port assertions for the config top
// assumes it is bound into every svpc_config_top
`timescale 1ns/1ps
`default_nettype none
module svpc_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic cfgWrEn,
	input wire logic cfgRdEn,
	input wire logic cfgRdValid,
	input wire logic [7:0] negFullDuplex,
	input wire logic [7:0] partnerFullDuplex,
	input wire logic [7:0] partnerPause,
	input wire logic [7:0] cableDetected,
	input wire logic [7:0] effFullDuplex,
	input wire logic [7:0] flpReduce,
	input wire logic [15:0] xcvrTestBits,
	input wire logic fwdReqValid,
	input wire logic [2:0] fwdSrcPort,
	input wire logic [7:0] fwdDstMask,
	input wire logic fwdAllowValid,
	input wire logic [7:0] fwdAllowMask
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_RD_ANSWER: assert property (cfgRdEn |=> cfgRdValid)
		else $error("read answer missing");
	AST_FWD_ANSWER: assert property (fwdReqValid |=> fwdAllowValid)
		else $error("forward answer missing");
	AST_FWD_IDLE: assert property (!fwdReqValid |=> fwdAllowMask == 8'h00)
		else $error("allow mask set with no request");
	AST_FWD_SUBSET: assert property (fwdReqValid |=>
		(fwdAllowMask & ~$past(fwdDstMask)) == 8'h00) else $error("extra port");
	AST_OWN_BIT: assert property (fwdReqValid |=>
		!fwdAllowMask[$past(fwdSrcPort)]) else $error("frame sent to source");
	AST_UNFILTERED: assert property (fwdReqValid && fwdSrcPort > 3'h1 |=>
		fwdAllowMask == ($past(fwdDstMask) & ~(8'h01 << $past(fwdSrcPort))))
		else $error("unfiltered source trimmed");
	AST_FALLBACK: assert property (!cfgWrEn |=> effFullDuplex == $past(
		negFullDuplex & ~({8{xcvrTestBits[12]}} & partnerFullDuplex
		& ~partnerPause))) else $error("duplex fallback wrong");
	AST_PULSE: assert property (!cfgWrEn |=> flpReduce ==
		$past({8{~xcvrTestBits[3]}} & ~cableDetected)) else $error("pulse wrong");
endmodule : svpc_monitor
bind svpc_config_top svpc_monitor u_mon (.clk, .rst, .cfgWrEn, .cfgRdEn,
	.cfgRdValid, .negFullDuplex, .partnerFullDuplex, .partnerPause,
	.cableDetected, .effFullDuplex, .flpReduce, .xcvrTestBits, .fwdReqValid,
	.fwdSrcPort, .fwdDstMask, .fwdAllowValid, .fwdAllowMask);
`default_nettype wire

/* dv/svpc_loader_model.sv */
// svpc_loader_model: config loader on the register port
// assumes the bench calls acc and boot; strobes move on falling edges
`timescale 1ns/1ps
`default_nettype none
module svpc_loader_model (
	input wire logic clk,
	output logic wrEn,
	output logic rdEn,
	output logic [7:0] addr,
	output logic [15:0] wrData
);
	initial {wrEn, rdEn, addr, wrData} = 26'h0000000;
	// one strobe cycle; released lines show inverted junk, not stale data
	task acc(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		wrEn = w;
		rdEn = !w;
		addr = a;
		wrData = d;
		@(negedge clk);
		{wrEn, rdEn, addr, wrData} = {2'h0, ~a, ~d};
	endtask : acc
	// normal-use setup: test bits zero, pulse control left disabled
	task boot;
		acc(1'b1, 8'h05, 16'h1008);
		acc(1'b1, 8'h06, 16'h0000);
	endtask : boot
endmodule : svpc_loader_model
`default_nettype wire

/* dv/testbench.sv */
// testbench: reads, status and forwarding checks on svpc_config_top
// assumes the loader model owns the register port
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cfgWrEn, cfgRdEn, cfgRdValid, fwdReqValid, fwdAllowValid;
	logic [15:0] cfgWrData, cfgRdData, xcvrTestBits, vlan, rdQ[$];
	logic [7:0] cfgAddr, negFullDuplex, partnerFullDuplex, partnerPause;
	logic [7:0] cableDetected, effFullDuplex, flpReduce, fwdDstMask;
	logic [7:0] fwdAllowMask, mem, fwQ[$];
	logic [6:0] testModeBits;
	logic [2:0] fwdSrcPort;
	int miscompares = 0, tests_run = 0, cycles = 0, seed = 32'he088;
	always #4 clk = ~clk;
	svpc_config_top u_dut (.clk, .rst, .cfgWrEn, .cfgRdEn, .cfgAddr,
		.cfgWrData, .cfgRdData, .cfgRdValid, .negFullDuplex, .partnerFullDuplex,
		.partnerPause, .cableDetected, .effFullDuplex, .flpReduce, .xcvrTestBits,
		.testModeBits, .fwdReqValid, .fwdSrcPort, .fwdDstMask, .fwdAllowValid,
		.fwdAllowMask);
	svpc_loader_model u_ldr (.clk, .wrEn(cfgWrEn), .rdEn(cfgRdEn),
		.addr(cfgAddr), .wrData(cfgWrData));
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task report_and_stop;
		$display("tests %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	task rd(input logic [7:0] a, input logic [15:0] e);
		rdQ.push_back(e);
		u_ldr.acc(1'b0, a, 16'h0000);
	endtask : rd
	task fw(input logic [2:0] s, input logic [7:0] d);
		mem = (s == 3'h0) ? vlan[7:0] : (s == 3'h1) ? vlan[15:8] : 8'hff;
		fwQ.push_back(d & mem & ~(8'h01 << s));
		@(negedge clk);
		{fwdReqValid, fwdSrcPort, fwdDstMask} = {1'b1, s, d};
	endtask : fw
	// result watcher pops the oldest note per answer; also the hang limit
	always @(negedge clk) begin
		if (cfgRdValid === 1'b1) cmp(cfgRdData, rdQ.pop_front());
		if (fwdAllowValid === 1'b1) cmp(16'(fwdAllowMask), 16'(fwQ.pop_front()));
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			report_and_stop();
		end
	end
	initial begin
		{fwdReqValid, fwdSrcPort, fwdDstMask} = 12'h000;
		{negFullDuplex, partnerFullDuplex, partnerPause, cableDetected} = 0;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		cmp(xcvrTestBits, 16'h1008);
		cmp(16'(testModeBits), 16'h0000);
		rd(8'h05, 16'h1008);
		rd(8'h06, 16'h0000);
		rd(8'h07, 16'hffff);
		rd(8'h08, 16'h0000);
		u_ldr.acc(1'b1, 8'h05, 16'hffff);
		u_ldr.acc(1'b1, 8'h06, 16'hffff);
		rd(8'h05, 16'h3fff);
		rd(8'h06, 16'h007f);
		cmp(xcvrTestBits, 16'h3fff);
		cmp(16'(testModeBits), 16'h007f);
		$display("reset and register test done");
		// back to normal-use settings before the status and forwarding tests
		u_ldr.boot();
		cmp(xcvrTestBits, 16'h1008);
		cmp(16'(testModeBits), 16'h0000);
		// every fallback and pulse control setting under random status
		for (int i = 0; i < 4; i++) begin
			u_ldr.acc(1'b1, 8'h05, {3'h0, i[1], 8'h00, i[0], 3'h0});
			repeat (8) begin
				@(negedge clk);
				{negFullDuplex, partnerFullDuplex, partnerPause, cableDetected}
					= $random(seed);
				@(negedge clk);
				cmp(16'(effFullDuplex), 16'(negFullDuplex & ~({8{i[1]}}
					& partnerFullDuplex & ~partnerPause)));
				cmp(16'(flpReduce), 16'({8{~i[0]}} & ~cableDetected));
			end
		end
		$display("status test done");
		// back-to-back frames from every source under random masks
		for (int k = 0; k < 6; k++) begin
			vlan = (k == 0) ? 16'hffff : 16'($random(seed));
			u_ldr.acc(1'b1, 8'h07, vlan);
			rd(8'h07, vlan);
			for (int s = 0; s < 8; s++) fw(3'(s), 8'($random(seed)));
			@(negedge clk);
			{fwdReqValid, fwdSrcPort, fwdDstMask} = ~{1'b1, fwdSrcPort, fwdDstMask};
		end
		repeat (3) @(negedge clk);
		$display("forwarding test done");
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
